// File: src/udb_pkg.sv
// package of the serial data buffer block: register map, field layouts,
// reset values and state enumerations.
// assumes an 8-bit register port with a 4-bit word address.
package udb_pkg;

  // ************************************************************
  // register map (word addresses)
  // ************************************************************
  localparam logic [3:0] ADDR_DATA     = 4'h0; // receive_buffer / transmit_holding
  localparam logic [3:0] ADDR_IRQ_EN   = 4'h1;
  localparam logic [3:0] ADDR_STATUS   = 4'h2;
  localparam logic [3:0] ADDR_LINE     = 4'h3;
  localparam logic [3:0] ADDR_MODE     = 4'h4;
  localparam logic [3:0] ADDR_SCRATCH  = 4'h5;
  localparam logic [3:0] ADDR_DIV_LO   = 4'h6;
  localparam logic [3:0] ADDR_DIV_HI   = 4'h7;
  localparam logic [3:0] ADDR_STATE    = 4'h8;
  localparam logic [3:0] ADDR_RX_LEVEL = 4'h9;
  localparam logic [3:0] ADDR_TX_LEVEL = 4'ha;

  // ************************************************************
  // status / irq enable bit positions
  // ************************************************************
  localparam int ST_RX_AVAIL  = 0;
  localparam int ST_HOLD_EMPT = 1;
  localparam int ST_OVERRUN   = 2;
  localparam int ST_LINE_ERR  = 3;
  localparam int ST_WIDTH     = 4;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [3:0]  IRQ_EN_RESET  = 4'h0;
  localparam logic [4:0]  LINE_RESET    = 5'h03; // 8 data bits, 1 stop
  localparam logic [3:0]  MODE_RESET    = 4'h0;  // single-character mode
  localparam logic [7:0]  SCRATCH_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET     = 16'h0001;

  // ************************************************************
  // timing counts, in 16x ticks
  // ************************************************************
  localparam logic [4:0] TICKS_BIT      = 5'h10;
  localparam logic [4:0] TICKS_HALF     = 5'h08;
  localparam logic [4:0] TICKS_STOP_1H  = 5'h18;
  localparam logic [4:0] TICKS_STOP_2   = 5'h20;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic       parity_even;
    logic       parity_en;
    logic       two_stop;
    logic [1:0] word_len;    // 0..3 -> 5..8 data bits
  } udb_line_t;

  typedef struct packed {
    logic [1:0] rx_trigger;  // fifo mode: 1, 4, 8, 14 bytes
    logic       loopback;
    logic       fifo_mode;
  } udb_mode_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
  } udb_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
  } udb_rx_state_t;

endpackage

// File: src/udb_data_buffers.sv
// serial data buffer block: receive and transmit byte stores, shift
// registers, baud generator, interrupt flags and scratch register.
// assumes a single-cycle register port on sys_clk_in; serial input and the
// 16x receive clock come from pins and are synchronised here.
//
// Operation
// - receive buffer is a fifo of up to sixteen bytes.
// - receiver timing comes from the 16x receive clock input.
// - serial input shifts into a shift register, then moves into the buffer.
// - single-character mode: character entering buffer raises irq if enable bit0.
// - reading the receive buffer clears the received-data interrupt.
// - fifo mode: interrupts follow fifo control settings instead.
// - 8-bit scratch register, read back, affects nothing else.
// - transmit holding store is a fifo of up to sixteen bytes.
// - transmitter timing comes from the baud generator output.
// - next byte moves to the shift register only when it is idle.
// - shift register contents are serialised onto the serial output.
// - single-character mode: holding empty raises irq if enable bit1.
// - writing the transmit holding register clears the holding-empty interrupt.
// - line control settings govern framing of receiver and transmitter.
// - writing either divisor byte reloads the 16-bit baud counter.
// - loopback feeds transmit output to receiver, ignoring the serial input.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module udb_data_buffers #(
  parameter int DEPTH = 16
) (
  input  wire logic       sys_clk_in,                  // 100 MHz clock
  input  wire logic       arst_n_in,                   // async reset, low
  input  wire logic [3:0] addr_in,                     // register address
  input  wire logic [7:0] wdata_in,                    // write data
  input  wire logic       wr_in,                       // write strobe
  input  wire logic       rd_in,                       // read strobe
  output logic      [7:0] rdata_out,                   // read data, next cycle
  input  wire logic       serial_input_in,             // serial line in
  input  wire logic       rx_clk16_in,                 // 16x receive clock pin
  output logic            serial_output_out,           // serial line out
  output logic            baud_generator_output_out,   // 16x baud tick
  output logic            irq_out                      // level interrupt
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  // ************************************************************
  // register file
  // ************************************************************
  logic [3:0]          irq_en;
  logic [udb_pkg::ST_WIDTH-1:0] status;
  udb_pkg::udb_line_t  line_cfg;
  udb_pkg::udb_mode_t  mode_cfg;
  logic [7:0]          scratch_pad;
  logic [15:0]         divisor;

  logic wr_data, rd_data, wr_div;
  assign wr_data = wr_in && (addr_in == udb_pkg::ADDR_DATA);
  assign rd_data = rd_in && (addr_in == udb_pkg::ADDR_DATA);
  assign wr_div  = wr_in && (addr_in == udb_pkg::ADDR_DIV_LO ||
                             addr_in == udb_pkg::ADDR_DIV_HI);

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_en      <= udb_pkg::IRQ_EN_RESET;
      line_cfg    <= udb_pkg::LINE_RESET;
      mode_cfg    <= udb_pkg::MODE_RESET;
      scratch_pad <= udb_pkg::SCRATCH_RESET;
      divisor     <= udb_pkg::DIV_RESET;
    end else if (wr_in) begin
      case (addr_in)
        udb_pkg::ADDR_IRQ_EN:  irq_en      <= wdata_in[3:0];
        udb_pkg::ADDR_LINE:    line_cfg    <= wdata_in[4:0];
        udb_pkg::ADDR_MODE:    mode_cfg    <= wdata_in[3:0];
        udb_pkg::ADDR_SCRATCH: scratch_pad <= wdata_in;
        udb_pkg::ADDR_DIV_LO:  divisor[7:0]  <= wdata_in;
        udb_pkg::ADDR_DIV_HI:  divisor[15:8] <= wdata_in;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // baud generator
  // ************************************************************
  logic [15:0] baud_cnt;
  logic        baud_tick;
  logic [15:0] next_divisor;

  always_comb begin
    next_divisor = divisor;
    if (wr_in && addr_in == udb_pkg::ADDR_DIV_LO)
      next_divisor[7:0] = wdata_in;
    if (wr_in && addr_in == udb_pkg::ADDR_DIV_HI)
      next_divisor[15:8] = wdata_in;
  end

  // a zero divisor is treated as one so the counter never stalls
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      baud_cnt  <= udb_pkg::DIV_RESET;
      baud_tick <= 1'b0;
    end else if (wr_div) begin
      baud_cnt  <= next_divisor;
      baud_tick <= 1'b0;
    end else if (baud_cnt <= 16'h0001) begin
      baud_cnt  <= divisor;
      baud_tick <= 1'b1;
    end else begin
      baud_cnt  <= baud_cnt - 16'h0001;
      baud_tick <= 1'b0;
    end
  end

  assign baud_generator_output_out = baud_tick;

  // ************************************************************
  // pin synchronisers: three flops, act once the last two agree
  // ************************************************************
  logic [2:0] rclk_sync, sin_sync;
  logic       rclk_lvl, sin_lvl, rx_tick;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rclk_sync <= 3'h0;
      sin_sync  <= 3'h7;
      rclk_lvl  <= 1'b0;
      sin_lvl   <= 1'b1;
    end else begin
      rclk_sync <= {rclk_sync[1:0], rx_clk16_in};
      sin_sync  <= {sin_sync[1:0], serial_input_in};
      if (rclk_sync[1] == rclk_sync[2])
        rclk_lvl <= rclk_sync[2];
      if (sin_sync[1] == sin_sync[2])
        sin_lvl <= sin_sync[2];
    end
  end

  logic rclk_lvl_d;
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      rclk_lvl_d <= 1'b0;
    else
      rclk_lvl_d <= rclk_lvl;
  end
  assign rx_tick = rclk_lvl && !rclk_lvl_d;

  logic rx_line;
  assign rx_line = mode_cfg.loopback ? serial_output_out : sin_lvl;

  // ************************************************************
  // framing helpers
  // ************************************************************
  logic [2:0] last_bit;
  logic [7:0] data_mask;
  logic [4:0] stop_ticks;
  assign last_bit  = {1'b0, line_cfg.word_len} + 3'h4;
  assign data_mask = 8'hff >> (2'h3 - line_cfg.word_len);
  always_comb begin
    if (!line_cfg.two_stop)
      stop_ticks = udb_pkg::TICKS_BIT;
    else if (line_cfg.word_len == 2'h0)
      stop_ticks = udb_pkg::TICKS_STOP_1H;
    else
      stop_ticks = udb_pkg::TICKS_STOP_2;
  end

  function automatic logic parity_bit(input logic [7:0] d,
                                      input logic [7:0] m,
                                      input logic       even);
    logic p;
    p = ^(d & m);
    parity_bit = even ? p : ~p;
  endfunction

  // ************************************************************
  // byte stores
  // ************************************************************
  logic [7:0]    rx_mem [DEPTH];
  logic [7:0]    tx_mem [DEPTH];
  logic [PW-1:0] rx_wp, rx_rp, tx_wp, tx_rp;
  logic [CW-1:0] rx_cnt, tx_cnt, cap;
  logic          rx_push, rx_pop, tx_push, tx_pop;
  logic [7:0]    rx_word;
  logic          rx_store, rx_over;

  // single-character mode only uses the head entry
  assign cap     = mode_cfg.fifo_mode ? CW'(DEPTH) : CW'(1);
  assign rx_pop  = rd_data && (rx_cnt != '0);
  assign tx_push = wr_data && (tx_cnt < cap);

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_wp  <= '0;
      rx_rp  <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_store) begin
        rx_mem[rx_wp] <= rx_word;
        rx_wp <= (rx_wp == PW'(DEPTH - 1)) ? '0 : rx_wp + PW'(1);
      end
      if (rx_pop)
        rx_rp <= (rx_rp == PW'(DEPTH - 1)) ? '0 : rx_rp + PW'(1);
      rx_cnt <= rx_cnt + CW'(rx_store) - CW'(rx_pop);
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp] <= wdata_in;
        tx_wp <= (tx_wp == PW'(DEPTH - 1)) ? '0 : tx_wp + PW'(1);
      end
      if (tx_pop)
        tx_rp <= (tx_rp == PW'(DEPTH - 1)) ? '0 : tx_rp + PW'(1);
      tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
    end
  end

  // ************************************************************
  // transmitter
  // ************************************************************
  udb_pkg::udb_tx_state_t tx_state;
  logic [7:0] tx_shift;
  logic [2:0] tx_bitn;
  logic [4:0] tx_tcnt;
  logic       tx_par;

  assign tx_pop = (tx_state == udb_pkg::TX_IDLE) && (tx_cnt != '0);

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_state <= udb_pkg::TX_IDLE;
      tx_shift <= 8'h00;
      tx_bitn  <= 3'h0;
      tx_tcnt  <= 5'h00;
      tx_par   <= 1'b0;
    end else begin
      case (tx_state)
        udb_pkg::TX_IDLE: begin
          tx_tcnt <= 5'h00;
          if (tx_pop) begin
            tx_shift <= tx_mem[tx_rp];
            tx_par   <= parity_bit(tx_mem[tx_rp], data_mask,
                                   line_cfg.parity_even);
            tx_state <= udb_pkg::TX_START;
          end
        end
        udb_pkg::TX_START, udb_pkg::TX_DATA, udb_pkg::TX_PARITY: begin
          if (baud_tick) begin
            if (tx_tcnt == udb_pkg::TICKS_BIT - 5'h01) begin
              tx_tcnt <= 5'h00;
              if (tx_state == udb_pkg::TX_START) begin
                tx_bitn  <= 3'h0;
                tx_state <= udb_pkg::TX_DATA;
              end else if (tx_state == udb_pkg::TX_DATA) begin
                tx_shift <= tx_shift >> 1;
                tx_bitn  <= tx_bitn + 3'h1;
                if (tx_bitn == last_bit)
                  tx_state <= line_cfg.parity_en ? udb_pkg::TX_PARITY
                                                 : udb_pkg::TX_STOP;
              end else begin
                tx_state <= udb_pkg::TX_STOP;
              end
            end else begin
              tx_tcnt <= tx_tcnt + 5'h01;
            end
          end
        end
        udb_pkg::TX_STOP: begin
          if (baud_tick) begin
            if (tx_tcnt == stop_ticks - 5'h01) begin
              tx_tcnt  <= 5'h00;
              tx_state <= udb_pkg::TX_IDLE;
            end else begin
              tx_tcnt <= tx_tcnt + 5'h01;
            end
          end
        end
        default: tx_state <= udb_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      serial_output_out <= 1'b1;
    else begin
      case (tx_state)
        udb_pkg::TX_START:  serial_output_out <= 1'b0;
        udb_pkg::TX_DATA:   serial_output_out <= tx_shift[0];
        udb_pkg::TX_PARITY: serial_output_out <= tx_par;
        default:            serial_output_out <= 1'b1;
      endcase
    end
  end

  // ************************************************************
  // receiver
  // ************************************************************
  udb_pkg::udb_rx_state_t rx_state;
  logic [7:0] rx_shift;
  logic [2:0] rx_bitn;
  logic [3:0] rx_tcnt;
  logic       rx_par_bad, rx_err;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_state   <= udb_pkg::RX_IDLE;
      rx_shift   <= 8'h00;
      rx_bitn    <= 3'h0;
      rx_tcnt    <= 4'h0;
      rx_par_bad <= 1'b0;
      rx_push    <= 1'b0;
      rx_word    <= 8'h00;
      rx_err     <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      rx_err  <= 1'b0;
      if (rx_tick) begin
        case (rx_state)
          udb_pkg::RX_IDLE: begin
            rx_tcnt <= 4'h0;
            if (!rx_line) begin
              rx_shift   <= 8'h00;
              rx_par_bad <= 1'b0;
              rx_state   <= udb_pkg::RX_START;
            end
          end
          udb_pkg::RX_START: begin
            // re-check at mid bit so a glitch is not taken as a start
            if (rx_tcnt == 4'(udb_pkg::TICKS_HALF - 5'h01)) begin
              rx_tcnt  <= 4'h0;
              rx_bitn  <= 3'h0;
              rx_state <= rx_line ? udb_pkg::RX_IDLE : udb_pkg::RX_DATA;
            end else begin
              rx_tcnt <= rx_tcnt + 4'h1;
            end
          end
          udb_pkg::RX_DATA: begin
            rx_tcnt <= rx_tcnt + 4'h1;
            if (rx_tcnt == 4'hf) begin
              rx_shift[rx_bitn] <= rx_line;
              rx_bitn <= rx_bitn + 3'h1;
              if (rx_bitn == last_bit)
                rx_state <= line_cfg.parity_en ? udb_pkg::RX_PARITY
                                               : udb_pkg::RX_STOP;
            end
          end
          udb_pkg::RX_PARITY: begin
            rx_tcnt <= rx_tcnt + 4'h1;
            if (rx_tcnt == 4'hf) begin
              rx_par_bad <= rx_line != parity_bit(rx_shift, data_mask,
                                                  line_cfg.parity_even);
              rx_state   <= udb_pkg::RX_STOP;
            end
          end
          udb_pkg::RX_STOP: begin
            rx_tcnt <= rx_tcnt + 4'h1;
            if (rx_tcnt == 4'hf) begin
              rx_word  <= rx_shift;
              rx_push  <= 1'b1;
              rx_err   <= rx_par_bad || !rx_line;
              rx_state <= udb_pkg::RX_IDLE;
            end
          end
          default: rx_state <= udb_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // a full store drops the new character and flags an overrun
  assign rx_store = rx_push && (rx_cnt < cap);
  assign rx_over  = rx_push && !(rx_cnt < cap);

  // ************************************************************
  // interrupt flags: events set, write-one clears, set wins
  // ************************************************************
  logic [4:0] trig_lvl;
  logic       tx_empty, tx_empty_d, rx_event;
  logic [udb_pkg::ST_WIDTH-1:0] set_bits, clr_bits;

  always_comb begin
    case (mode_cfg.rx_trigger)
      2'h0:    trig_lvl = 5'h01;
      2'h1:    trig_lvl = 5'h04;
      2'h2:    trig_lvl = 5'h08;
      default: trig_lvl = 5'h0e;
    endcase
  end

  assign tx_empty = (tx_cnt == '0);
  // single-character mode: every stored character; fifo mode: level
  assign rx_event = mode_cfg.fifo_mode
                  ? (rx_store && (5'(rx_cnt) + 5'h01 >= trig_lvl))
                  : rx_store;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      tx_empty_d <= 1'b0;
    else
      tx_empty_d <= tx_empty;
  end

  always_comb begin
    set_bits = '0;
    set_bits[udb_pkg::ST_RX_AVAIL]  = rx_event;
    set_bits[udb_pkg::ST_HOLD_EMPT] = tx_empty && !tx_empty_d;
    set_bits[udb_pkg::ST_OVERRUN]   = rx_over;
    set_bits[udb_pkg::ST_LINE_ERR]  = rx_store && rx_err;
    clr_bits = '0;
    if (wr_in && addr_in == udb_pkg::ADDR_STATUS)
      clr_bits = wdata_in[udb_pkg::ST_WIDTH-1:0];
    if (rd_data)
      clr_bits[udb_pkg::ST_RX_AVAIL] = 1'b1;
    if (wr_data)
      clr_bits[udb_pkg::ST_HOLD_EMPT] = 1'b1;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      status <= '0;
    else
      status <= (status & ~clr_bits) | set_bits;
  end

  assign irq_out = |(status & irq_en);

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      rdata_out <= 8'h00;
    else if (rd_in) begin
      case (addr_in)
        udb_pkg::ADDR_DATA:
          rdata_out <= (rx_cnt != '0) ? rx_mem[rx_rp] : 8'h00;
        udb_pkg::ADDR_IRQ_EN:   rdata_out <= {4'h0, irq_en};
        udb_pkg::ADDR_STATUS:   rdata_out <= {4'h0, status};
        udb_pkg::ADDR_LINE:     rdata_out <= {3'h0, line_cfg};
        udb_pkg::ADDR_MODE:     rdata_out <= {4'h0, mode_cfg};
        udb_pkg::ADDR_SCRATCH:  rdata_out <= scratch_pad;
        udb_pkg::ADDR_DIV_LO:   rdata_out <= divisor[7:0];
        udb_pkg::ADDR_DIV_HI:   rdata_out <= divisor[15:8];
        udb_pkg::ADDR_STATE:
          rdata_out <= {4'h0, tx_state == udb_pkg::TX_IDLE, tx_empty,
                        tx_cnt >= cap, rx_cnt != '0};
        udb_pkg::ADDR_RX_LEVEL: rdata_out <= 8'(rx_cnt);
        udb_pkg::ADDR_TX_LEVEL: rdata_out <= 8'(tx_cnt);
        default:                rdata_out <= 8'h00;
      endcase
    end else
      rdata_out <= 8'h00;
  end

endmodule

// File: test/udb_data_buffers_assertions.sv
// checker of the serial data buffer block, bound from the bench.
// assumes the divisor high byte stays at its reset value.
`timescale 1ns/1ps
module udb_data_buffers_assertions (
  input wire logic       sys_clk_in,                // clock
  input wire logic       arst_n_in,                 // reset
  input wire logic [3:0] addr_in,                   // address
  input wire logic [7:0] wdata_in,                  // write data
  input wire logic       wr_in,                     // write
  input wire logic       rd_in,                     // read
  input wire logic [7:0] rdata_out,                 // read data
  input wire logic       serial_output_out,         // line out
  input wire logic       baud_generator_output_out, // baud tick
  input wire logic       irq_out                    // interrupt
);
  logic [3:0] en;
  logic [7:0] scr, dlo;
  logic       fifo, sent;
  // ****
  // mirrors of software writes, so the properties see register state
  // ****
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en   <= udb_pkg::IRQ_EN_RESET;
      scr  <= udb_pkg::SCRATCH_RESET;
      dlo  <= udb_pkg::DIV_RESET[7:0];
      fifo <= 1'b0;
      sent <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == udb_pkg::ADDR_IRQ_EN) en <= wdata_in[3:0];
      if (addr_in == udb_pkg::ADDR_SCRATCH) scr <= wdata_in;
      if (addr_in == udb_pkg::ADDR_DIV_LO) dlo <= wdata_in;
      if (addr_in == udb_pkg::ADDR_MODE) fifo <= wdata_in[0];
      if (addr_in == udb_pkg::ADDR_DATA) sent <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_rd_idle; !rd_in |=> rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_scr;
    rd_in && addr_in == udb_pkg::ADDR_SCRATCH |=> rdata_out == scr;
  endproperty
  a_scr: assert property (p_scr) else $error("scratch readback");
  property p_unmap; rd_in && addr_in > 4'ha |=> rdata_out == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_mask; en == 4'h0 |-> !irq_out; endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_tx_idle; !sent |-> serial_output_out; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("line not idle");
  property p_baud;
    $rose(baud_generator_output_out) && dlo == 8'h04 |=>
      !baud_generator_output_out [*3] ##1 baud_generator_output_out;
  endproperty
  a_baud: assert property (p_baud) else $error("baud period");
  property p_wr_clr;
    wr_in && addr_in == udb_pkg::ADDR_DATA && en == 4'h2 && !fifo |=> !irq_out;
  endproperty
  a_wr_clr: assert property (p_wr_clr) else $error("hold irq kept");
  property p_rd_clr;
    rd_in && addr_in == udb_pkg::ADDR_DATA && en == 4'h1 && !fifo |=> !irq_out;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("rx irq kept");
  c_tx: cover property (wr_in && addr_in == udb_pkg::ADDR_DATA);
  c_irq: cover property ($rose(irq_out));
  c_rd: cover property (rd_in && addr_in == udb_pkg::ADDR_DATA && irq_out);
endmodule

// File: test/udb_serial_peer.sv
// serial peer: drives the receive line and the 16x receive clock, and
// decodes the transmit line at the divisor held in div.
`timescale 1ns/1ps
module udb_serial_peer (
  input  wire logic sys_clk_in, // bench clock
  input  wire logic line_in,    // line from the block
  output logic      rclk_out,   // 16x receive clock
  output logic      line_out    // line to the block, idles high
);
  logic [7:0] got[$];
  logic [7:0] v;
  int         div = 1; // divisor the bench has programmed
  initial begin
    rclk_out = 1'b0;
    line_out = 1'b1;
  end
  // eight system clocks per tick, slow enough for the pin synchroniser
  always #40 rclk_out = ~rclk_out;
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge rclk_out);
      line_out = f[i];
      repeat (15) @(posedge rclk_out);
    end
  endtask
  always begin
    @(negedge line_in);
    repeat (8 * div) @(posedge sys_clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (16 * div) @(posedge sys_clk_in);
      v[i] = line_in;
    end
    repeat (12 * div) @(posedge sys_clk_in);
    got.push_back(v);
  end
endmodule

// File: test/udb_data_buffers_tb.sv
// self-checking bench of the serial data buffer block.
// assumes the peer model on the pins; divisor one until the loopback test.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module udb_data_buffers_tb;
  logic       sys_clk_in = 1'b0;
  logic       arst_n_in  = 1'b0;
  logic [3:0] addr_in    = 4'h0;
  logic [7:0] wdata_in   = 8'h00;
  logic       wr_in      = 1'b0;
  logic       rd_in      = 1'b0;
  logic [7:0] rdata_out, rq, b;
  logic       serial_input_in, rx_clk16_in, serial_output_out, baud, irq_out;
  logic       hit;
  int         error_cnt, checks, n;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  always #5 sys_clk_in = ~sys_clk_in;
  udb_data_buffers uut (.sys_clk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .serial_input_in, .rx_clk16_in, .serial_output_out,
    .baud_generator_output_out(baud), .irq_out);
  udb_serial_peer peer (.sys_clk_in, .line_in(serial_output_out),
    .rclk_out(rx_clk16_in), .line_out(serial_input_in));
  // ****
  // bus tasks: reads leave a gap cycle to pick up the data
  // ****
  task automatic bus(input logic w, r, input logic [3:0] a, input logic [7:0] d);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    if (r) begin
      rd_in <= 1'b0;
      @(negedge sys_clk_in);
      rq = rdata_out;
      @(posedge sys_clk_in);
    end
  endtask
  task automatic idle(input int k);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (k) @(posedge sys_clk_in);
  endtask
  task automatic wirq;
    idle(0);
    for (n = 0; n < 6000; n++) begin
      @(negedge sys_clk_in);
      hit = irq_out;
      if (hit === 1'b1) break;
    end
    @(posedge sys_clk_in);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    error_cnt++;
    end_sim;
  end
  initial begin
    void'($urandom(47906));
    repeat (20) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    bus(0, 1, udb_pkg::ADDR_IRQ_EN, 8'h00);
    `CHK("irq_en", {4'h0, udb_pkg::IRQ_EN_RESET}, rq)
    bus(0, 1, udb_pkg::ADDR_LINE, 8'h00);
    `CHK("line", {3'h0, udb_pkg::LINE_RESET}, rq)
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      bus(1, 0, udb_pkg::ADDR_SCRATCH, b);
      bus(1, 0, 4'hc, ~b);
      bus(0, 1, udb_pkg::ADDR_SCRATCH, 8'h00);
      `CHK("scratch", b, rq)
      bus(0, 1, 4'hc, 8'h00);
      `CHK("unmapped", 8'h00, rq)
    end
    bus(1, 0, udb_pkg::ADDR_IRQ_EN, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wirq;
      `CHK("hold_irq", 1'b1, hit)
      b = 8'($urandom);
      txq.push_back(b);
      bus(1, 0, udb_pkg::ADDR_DATA, b);
    end
    bus(1, 0, udb_pkg::ADDR_IRQ_EN, 8'h00);
    idle(400);
    bus(1, 0, udb_pkg::ADDR_MODE, 8'h05);
    for (int i = 0; i < 18; i++) begin
      b = 8'($urandom);
      if (i < 17) txq.push_back(b);
      bus(1, 0, udb_pkg::ADDR_DATA, b);
    end
    bus(0, 1, udb_pkg::ADDR_TX_LEVEL, 8'h00);
    `CHK("tx_level", 8'h10, rq)
    idle(3000);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      rxq.push_back(b);
      peer.send(b);
    end
    idle(40);
    bus(0, 1, udb_pkg::ADDR_RX_LEVEL, 8'h00);
    `CHK("rx_level", 8'h03, rq)
    bus(0, 1, udb_pkg::ADDR_STATUS, 8'h00);
    `CHK("rx_trig", 1'b0, rq[udb_pkg::ST_RX_AVAIL])
    while (rxq.size() > 0) begin
      b = rxq.pop_front();
      bus(0, 1, udb_pkg::ADDR_DATA, 8'h00);
      `CHK("rx_data", b, rq)
    end
    bus(1, 0, udb_pkg::ADDR_MODE, 8'h00);
    bus(1, 0, udb_pkg::ADDR_IRQ_EN, 8'h01);
    idle(1);
    b = 8'($urandom);
    peer.send(b);
    wirq;
    `CHK("rx_irq", 1'b1, hit)
    bus(0, 1, udb_pkg::ADDR_DATA, 8'h00);
    `CHK("rx_single", b, rq)
    // loopback needs the baud tick at the receive tick rate
    bus(1, 0, udb_pkg::ADDR_DIV_LO, 8'h08);
    peer.div = 8;
    bus(1, 0, udb_pkg::ADDR_MODE, 8'h02);
    b = 8'($urandom);
    txq.push_back(b);
    bus(1, 0, udb_pkg::ADDR_DATA, b);
    wirq;
    bus(0, 1, udb_pkg::ADDR_DATA, 8'h00);
    `CHK("loopback", b, rq)
    idle(300);
    `CHK("tx_count", txq.size(), peer.got.size())
    foreach (txq[i]) `CHK("tx_data", txq[i], peer.got[i])
    bus(1, 0, udb_pkg::ADDR_DIV_LO, 8'h04);
    idle(3);
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge sys_clk_in);
      n += baud;
    end
    `CHK("baud_pulses", 10, n)
    end_sim;
  end
endmodule
bind udb_data_buffers udb_data_buffers_assertions chk (.sys_clk_in, .arst_n_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .serial_output_out,
  .baud_generator_output_out, .irq_out);
